/* gpd_pkg.sv */
// gpd_pkg: constants, register map and carrier types of the dual-port gpio block.
// assumes: byte-wide register port, one core clock, pins synchronised inside the block.
package gpd_pkg;

    // port geometry
    localparam int PORT_W = 8;
    localparam int DRV_W = 4;
    localparam int HC_W_FULL = 8;
    localparam int HC_W_REDUCED = 4;

    // clocking: core clock is twice the resonator
    localparam int RESONATOR_KHZ = 6000;
    localparam int CORE_MULT = 2;
    localparam int CORE_KHZ = RESONATOR_KHZ * CORE_MULT;
    localparam int SYS_CLK_KHZ = 125000;

    // register offsets
    localparam logic [7:0] ADDR_LC_DATA = 8'h00;
    localparam logic [7:0] ADDR_HC_DATA = 8'h01;
    localparam logic [7:0] ADDR_LC_IE = 8'h04;
    localparam logic [7:0] ADDR_HC_IE = 8'h05;
    localparam logic [7:0] ADDR_WK_IE = 8'h06;
    localparam logic [7:0] ADDR_LC_PU = 8'h08;
    localparam logic [7:0] ADDR_HC_PU = 8'h09;
    localparam logic [7:0] ADDR_LC_POL = 8'h30;
    localparam logic [7:0] ADDR_HC_POL = 8'h31;
    localparam logic [7:0] ADDR_LC_STAT = 8'h34;
    localparam logic [7:0] ADDR_HC_STAT = 8'h35;
    localparam logic [7:0] ADDR_WK_STAT = 8'h36;
    localparam logic [7:0] ADDR_LC_CLR = 8'h38;
    localparam logic [7:0] ADDR_HC_CLR = 8'h39;
    localparam logic [7:0] ADDR_WK_CLR = 8'h3a;
    localparam logic [7:0] ADDR_WK_CTRL = 8'h3c;
    localparam logic [7:0] ADDR_HC_LED = 8'h3d;
    // drive registers: base plus pin index, low port 0..7, high port 8..15
    localparam logic [7:0] ADDR_DRV_BASE = 8'h40;
    localparam logic [7:0] ADDR_DRV_LAST = 8'h4f;

    // wake control fields
    localparam int WK_DRIVE_BIT = 0;
    localparam int WK_SUSP_BIT = 1;
    localparam int WK_LEVEL_BIT = 2;

    // reset values
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_IE = 8'h00;
    localparam logic [7:0] RST_PU = 8'hff;
    localparam logic [7:0] RST_POL = 8'hff;
    localparam logic [7:0] RST_LED = 8'h00;
    localparam logic [3:0] RST_DRV = 4'hf;

    // pad bundle of one port
    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe_n;
    } gpd_pads_t;

    // configuration of one port
    typedef struct packed {
        logic [PORT_W-1:0] data;
        logic [PORT_W-1:0] ie;
        logic [PORT_W-1:0] pu;
        logic [PORT_W-1:0] pol;
        logic [PORT_W-1:0] stat;
        logic [PORT_W*DRV_W-1:0] drv;
    } gpd_port_cfg_t;

endpackage : gpd_pkg

/* gpd_pin_sync.sv */
// gpd_pin_sync: two-stage synchroniser and polarity-selected edge detector per pin.
// assumes: pin inputs are asynchronous; polarity comes from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module gpd_pin_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] pin,
    input wire logic [W-1:0] rise_sel,
    output logic [W-1:0] level,
    output logic [W-1:0] edge_hit
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] last_r;
    // edges stay masked until the sync chain holds real pin levels
    logic [1:0] arm_r;

    initial begin
        if (W < 1) $error("gpd_pin_sync: width must be at least 1");
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= '0;
            arm_r <= 2'h0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
            if (arm_r != 2'h3) begin
                arm_r <= arm_r + 2'h1;
            end
        end
    end

    assign level = sync_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            // rising when selected, otherwise falling
            assign edge_hit[i] = (arm_r == 2'h3) &&
                (rise_sel[i] ? (sync_r[i] & ~last_r[i]) : (~sync_r[i] & last_r[i]));
        end
    endgenerate

endmodule : gpd_pin_sync
`default_nettype wire

/* gpd_gpio.sv */
// gpd_gpio: two 8-bit gpio ports with pull-ups, drive strength, edge interrupts and a wake pin.
// assumes: byte register port on clk, pads resolved outside from out and active-low enables.
//
// Notes on behaviour
// - two ports, low-current and high-current, eight bidirectional lines each
// - reduced variant keeps only the lower four high-current lines, twelve total
// - each line has its own software-switched pull-up
// - each line has a four-bit sink strength, sixteen levels
// - high-current lines get LED-capable drivers, low-current port stays weak
// - interrupt lines fire on an edge of software-selected polarity per pin
// - each line's interrupt is maskable on its own
// - wake pin is open-drain with a rising-edge interrupt input
// - rising edge on the wake pin ends suspend
// - core clock is twice the resonator: 6 MHz gives 12 MHz
// - port data registers read-write at 0x00 and 0x01
// - interrupt enables write-only at 0x04 and 0x05
// - pull-up controls write-only at 0x08 and 0x09
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gpd_gpio
    import gpd_pkg::*;
#(
    parameter int HC_W = HC_W_FULL
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [PORT_W-1:0] low_current_port_lines_in,
    output gpd_pads_t low_current_port_lines_pad,
    input wire logic [PORT_W-1:0] high_current_port_lines_in,
    output gpd_pads_t high_current_port_lines_pad,
    output logic [PORT_W-1:0] low_current_pullup_en,
    output logic [PORT_W-1:0] high_current_pullup_en,
    output logic [PORT_W*DRV_W-1:0] low_current_sink_sel,
    output logic [PORT_W*DRV_W-1:0] high_current_sink_sel,
    output logic [PORT_W-1:0] high_current_led_en,
    input wire logic wake_pin_in,
    output logic wake_pin_out,
    output logic wake_pin_oe_n,
    output logic suspended,
    output logic wake_pulse,
    output logic irq
);

    localparam logic [PORT_W-1:0] HC_MASK = (HC_W == HC_W_FULL) ? 8'hff : 8'h0f;

    initial begin
        if (HC_W != HC_W_FULL && HC_W != HC_W_REDUCED)
            $error("gpd_gpio: HC_W must be 8 or 4");
        if (CORE_KHZ != 2 * RESONATOR_KHZ)
            $error("gpd_gpio: core clock must be twice the resonator");
    end

    // state
    gpd_port_cfg_t lc_r, lc_nxt;
    gpd_port_cfg_t hc_r, hc_nxt;
    logic [PORT_W-1:0] led_r, led_nxt;
    logic wk_ie_r, wk_ie_nxt;
    logic wk_stat_r, wk_stat_nxt;
    logic wk_drive_r, wk_drive_nxt;
    logic susp_r, susp_nxt;
    logic wk_pulse_r, wk_pulse_nxt;
    logic irq_r, irq_nxt;
    logic wk_drive_r_q;
    logic [7:0] rdata_r, rdata_nxt;
    gpd_pads_t lc_pad_r, lc_pad_nxt;
    gpd_pads_t hc_pad_r, hc_pad_nxt;

    // synchronised pins
    logic [2*PORT_W:0] sync_level;
    logic [2*PORT_W:0] sync_edge;
    logic [PORT_W-1:0] lc_level;
    logic [PORT_W-1:0] hc_level;
    logic [PORT_W-1:0] lc_edge;
    logic [PORT_W-1:0] hc_edge;
    logic wk_level;
    logic wk_edge;

    gpd_pin_sync #(
        .W(2 * PORT_W + 1)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin({wake_pin_in, high_current_port_lines_in, low_current_port_lines_in}),
        .rise_sel({1'b1, hc_r.pol, lc_r.pol}),
        .level(sync_level),
        .edge_hit(sync_edge)
    );

    assign lc_level = sync_level[PORT_W-1:0];
    assign hc_level = sync_level[2*PORT_W-1:PORT_W] & HC_MASK;
    assign wk_level = sync_level[2*PORT_W];
    assign lc_edge = sync_edge[PORT_W-1:0];
    assign hc_edge = sync_edge[2*PORT_W-1:PORT_W] & HC_MASK;
    assign wk_edge = sync_edge[2*PORT_W];

    logic wr_hit;
    logic [3:0] drv_idx;
    assign drv_idx = reg_addr[3:0];
    assign wr_hit = reg_wr && (reg_addr >= ADDR_DRV_BASE) && (reg_addr <= ADDR_DRV_LAST);

    always_comb begin
        lc_nxt = lc_r;
        hc_nxt = hc_r;
        led_nxt = led_r;
        wk_ie_nxt = wk_ie_r;
        wk_drive_nxt = wk_drive_r;
        susp_nxt = susp_r;
        rdata_nxt = 8'h00;

        if (reg_wr) begin
            case (reg_addr)
                ADDR_LC_DATA: lc_nxt.data = reg_wdata;
                ADDR_HC_DATA: hc_nxt.data = reg_wdata & HC_MASK;
                ADDR_LC_IE: lc_nxt.ie = reg_wdata;
                ADDR_HC_IE: hc_nxt.ie = reg_wdata & HC_MASK;
                ADDR_WK_IE: wk_ie_nxt = reg_wdata[0];
                ADDR_LC_PU: lc_nxt.pu = reg_wdata;
                ADDR_HC_PU: hc_nxt.pu = reg_wdata & HC_MASK;
                // polarity per pin, 1 = rising
                ADDR_LC_POL: lc_nxt.pol = reg_wdata;
                ADDR_HC_POL: hc_nxt.pol = reg_wdata;
                ADDR_WK_CTRL: begin
                    wk_drive_nxt = reg_wdata[WK_DRIVE_BIT];
                    susp_nxt = reg_wdata[WK_SUSP_BIT];
                end
                // led drive mode on high-current lines
                ADDR_HC_LED: led_nxt = reg_wdata & HC_MASK;
                default: begin
                end
            endcase
        end

        if (wr_hit) begin
            if (drv_idx < 4'h8)
                lc_nxt.drv[drv_idx[2:0]*DRV_W +: DRV_W] = reg_wdata[DRV_W-1:0];
            else if (HC_MASK[drv_idx[2:0]])
                hc_nxt.drv[drv_idx[2:0]*DRV_W +: DRV_W] = reg_wdata[DRV_W-1:0];
        end

        // pending flags, set wins over clear
        lc_nxt.stat = lc_r.stat;
        hc_nxt.stat = hc_r.stat;
        wk_stat_nxt = wk_stat_r;
        if (reg_wr && reg_addr == ADDR_LC_CLR)
            lc_nxt.stat = lc_r.stat & ~reg_wdata;
        if (reg_wr && reg_addr == ADDR_HC_CLR)
            hc_nxt.stat = hc_r.stat & ~reg_wdata;
        if (reg_wr && reg_addr == ADDR_WK_CLR && reg_wdata[0])
            wk_stat_nxt = 1'b0;
        lc_nxt.stat = lc_nxt.stat | lc_edge;
        hc_nxt.stat = hc_nxt.stat | hc_edge;
        wk_stat_nxt = wk_stat_nxt | wk_edge;

        wk_pulse_nxt = 1'b0;
        if (wk_edge && (susp_r || susp_nxt)) begin
            susp_nxt = 1'b0;
            wk_pulse_nxt = 1'b1;
        end

        irq_nxt = |(lc_nxt.stat & lc_nxt.ie) | |(hc_nxt.stat & hc_nxt.ie) | (wk_stat_nxt & wk_ie_nxt);

        if (reg_rd) begin
            case (reg_addr)
                ADDR_LC_DATA: rdata_nxt = lc_level;
                ADDR_HC_DATA: rdata_nxt = hc_level;
                ADDR_LC_POL: rdata_nxt = lc_r.pol;
                ADDR_HC_POL: rdata_nxt = hc_r.pol;
                ADDR_LC_STAT: rdata_nxt = lc_r.stat;
                ADDR_HC_STAT: rdata_nxt = hc_r.stat;
                ADDR_WK_STAT: rdata_nxt = {7'h00, wk_stat_r};
                ADDR_WK_CTRL: rdata_nxt = {5'h00, wk_level, susp_r, wk_drive_r};
                ADDR_HC_LED: rdata_nxt = led_r;
                default: begin
                    if (reg_addr >= ADDR_DRV_BASE && reg_addr <= ADDR_DRV_LAST) begin
                        if (drv_idx < 4'h8)
                            rdata_nxt = {4'h0, lc_r.drv[drv_idx[2:0]*DRV_W +: DRV_W]};
                        else
                            rdata_nxt = {4'h0, hc_r.drv[drv_idx[2:0]*DRV_W +: DRV_W]};
                    end
                end
            endcase
        end

        // bidirectional lines: a 0 sinks, a 1 releases to the pull-up
        lc_pad_nxt.out = lc_nxt.data;
        lc_pad_nxt.oe_n = lc_nxt.data;
        hc_pad_nxt.out = hc_nxt.data & HC_MASK;
        hc_pad_nxt.oe_n = hc_nxt.data | ~HC_MASK;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lc_r <= '{data: RST_DATA, ie: RST_IE, pu: RST_PU, pol: RST_POL, stat: 8'h00,
                      drv: {PORT_W{RST_DRV}}};
            hc_r <= '{data: RST_DATA, ie: RST_IE, pu: RST_PU, pol: RST_POL, stat: 8'h00,
                      drv: {PORT_W{RST_DRV}}};
            led_r <= RST_LED;
            wk_ie_r <= 1'b0;
            wk_stat_r <= 1'b0;
            wk_drive_r <= 1'b0;
            susp_r <= 1'b0;
            wk_pulse_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
            lc_pad_r <= '{out: 8'hff, oe_n: 8'hff};
            hc_pad_r <= '{out: 8'h00, oe_n: 8'hff};
        end else begin
            lc_r <= lc_nxt;
            hc_r <= hc_nxt;
            led_r <= led_nxt;
            wk_ie_r <= wk_ie_nxt;
            wk_stat_r <= wk_stat_nxt;
            wk_drive_r <= wk_drive_nxt;
            susp_r <= susp_nxt;
            wk_pulse_r <= wk_pulse_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            lc_pad_r <= lc_pad_nxt;
            hc_pad_r <= hc_pad_nxt;
        end
    end

    // outputs, all from flip-flops except wake_pin_out, which is tied low
    assign reg_rdata = rdata_r;
    assign low_current_port_lines_pad = lc_pad_r;
    assign high_current_port_lines_pad = hc_pad_r;
    assign low_current_pullup_en = lc_r.pu;
    assign high_current_pullup_en = hc_r.pu;
    assign low_current_sink_sel = lc_r.drv;
    assign high_current_sink_sel = hc_r.drv;
    assign high_current_led_en = led_r;
    // open drain: only ever pulls low
    assign wake_pin_out = 1'b0;
    assign wake_pin_oe_n = ~wk_drive_r_q;
    assign suspended = susp_r;
    assign wake_pulse = wk_pulse_r;
    assign irq = irq_r;

    // registered copy so the wake enable is a flop output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            wk_drive_r_q <= 1'b0;
        else
            wk_drive_r_q <= wk_drive_nxt;
    end

endmodule : gpd_gpio
`default_nettype wire

/* gpd_gpio_assertions.sv */
// gpd_gpio_assertions: port-level checks of the gpio block.
// assumes: bound to every gpd_gpio instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gpd_gpio_assertions
    import gpd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire gpd_pads_t low_current_port_lines_pad,
    input wire logic [7:0] low_current_pullup_en,
    input wire logic [31:0] low_current_sink_sel,
    input wire logic [7:0] high_current_led_en,
    input wire logic wake_pin_out,
    input wire logic wake_pin_oe_n,
    input wire logic suspended,
    input wire logic wake_pulse,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_data_oe; reg_wr && reg_addr == ADDR_LC_DATA |=> low_current_port_lines_pad.oe_n == $past(reg_wdata);
    endproperty
    a_data_oe: assert property (p_data_oe) else $error("data write not on pads");
    property p_ie_wo; reg_rd && (reg_addr == ADDR_LC_IE || reg_addr == ADDR_HC_IE) |=> reg_rdata == 8'h00;
    endproperty
    a_ie_wo: assert property (p_ie_wo) else $error("enable register readable");
    property p_pu_wo; reg_rd && (reg_addr == ADDR_LC_PU || reg_addr == ADDR_HC_PU) |=> reg_rdata == 8'h00;
    endproperty
    a_pu_wo: assert property (p_pu_wo) else $error("pull-up register readable");
    property p_pu_wr; reg_wr && reg_addr == ADDR_LC_PU |=> low_current_pullup_en == $past(reg_wdata); endproperty
    a_pu_wr: assert property (p_pu_wr) else $error("pull-up write lost");
    property p_sink_wr; reg_wr && reg_addr == ADDR_DRV_BASE |=> low_current_sink_sel[3:0] == $past(reg_wdata[3:0]);
    endproperty
    a_sink_wr: assert property (p_sink_wr) else $error("sink level write lost");
    property p_led_wr; reg_wr && reg_addr == ADDR_HC_LED |=> high_current_led_en == $past(reg_wdata); endproperty
    a_led_wr: assert property (p_led_wr) else $error("led enable write lost");
    property p_wake_od; reg_wr && reg_addr == ADDR_WK_CTRL |=> wake_pin_oe_n == !$past(reg_wdata[0]) && !wake_pin_out;
    endproperty
    a_wake_od: assert property (p_wake_od) else $error("wake pin not open drain");
    property p_wake_pulse; wake_pulse |-> !suspended ##1 !wake_pulse; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse wrong");
    c_irq: cover property ($rose(irq));
    c_wake: cover property (wake_pulse);
    c_stat: cover property (reg_rd && reg_addr == ADDR_LC_STAT);
endmodule : gpd_gpio_assertions
bind gpd_gpio gpd_gpio_assertions chk_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .low_current_port_lines_pad, .low_current_pullup_en, .low_current_sink_sel, .high_current_led_en,
    .wake_pin_out, .wake_pin_oe_n, .suspended, .wake_pulse, .irq);
`default_nettype wire

/* gpd_board.sv */
// gpd_board: board around the pins: pull-ups, switches, wake rc.
// assumes: an undriven line with no pull-up sits low on a weak board pull-down.
`timescale 1ns/1ps
`default_nettype none
module gpd_board
    import gpd_pkg::*;
(
    input wire gpd_pads_t lc_pad,
    input wire gpd_pads_t hc_pad,
    input wire logic [7:0] lc_pu,
    input wire logic [7:0] hc_pu,
    input wire logic [7:0] sw_en,
    input wire logic [7:0] sw_val,
    input wire logic wk_oe_n,
    input wire logic wk_rc,
    output logic [7:0] lc_lvl,
    output logic [7:0] hc_lvl,
    output logic wk_lvl
);
    assign lc_lvl = (~lc_pad.oe_n & lc_pad.out) | (lc_pad.oe_n & sw_en & sw_val) | (lc_pad.oe_n & ~sw_en & lc_pu);
    assign hc_lvl = (~hc_pad.oe_n & hc_pad.out) | (hc_pad.oe_n & hc_pu);
    assign wk_lvl = wk_oe_n & wk_rc;
endmodule : gpd_board
`default_nettype wire

/* gpd_gpio_test.sv */
// gpd_gpio_test: self-checking bench of the gpio block.
// assumes: gpd_board drives the pin inputs; bound checker watches ports.
`timescale 1ns/1ps
`default_nettype none
module gpd_gpio_test
    import gpd_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] sw_en = 8'h00;
    logic [7:0] sw_val = 8'h00;
    logic wk_rc = 1'b0;
    logic [7:0] reg_rdata, low_current_port_lines_in, high_current_port_lines_in;
    logic [7:0] low_current_pullup_en, high_current_pullup_en, high_current_led_en;
    logic [31:0] low_current_sink_sel, high_current_sink_sel;
    gpd_pads_t low_current_port_lines_pad, high_current_port_lines_pad;
    logic wake_pin_in, wake_pin_out, wake_pin_oe_n, suspended, wake_pulse, irq;
    int failures = 0;
    int num_checks = 0;

    gpd_gpio dut_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .low_current_port_lines_in, .low_current_port_lines_pad, .high_current_port_lines_in,
        .high_current_port_lines_pad, .low_current_pullup_en, .high_current_pullup_en, .low_current_sink_sel,
        .high_current_sink_sel, .high_current_led_en, .wake_pin_in, .wake_pin_out, .wake_pin_oe_n,
        .suspended, .wake_pulse, .irq);
    gpd_board brd_u (.lc_pad(low_current_port_lines_pad), .hc_pad(high_current_port_lines_pad),
        .lc_pu(low_current_pullup_en), .hc_pu(high_current_pullup_en), .sw_en, .sw_val,
        .wk_oe_n(wake_pin_oe_n), .wk_rc, .lc_lvl(low_current_port_lines_in),
        .hc_lvl(high_current_port_lines_in), .wk_lvl(wake_pin_in));

    always #4 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic t_reset;
        chk(low_current_port_lines_pad.oe_n, RST_DATA);
        chk(high_current_port_lines_pad.oe_n, RST_DATA);
        chk(low_current_pullup_en, RST_PU);
        chk(high_current_pullup_en, RST_PU);
        rd(ADDR_LC_STAT, 8'h00);
        rd(ADDR_HC_STAT, 8'h00);
        chk(low_current_sink_sel, {8{RST_DRV}});
        chk(high_current_led_en, RST_LED);
        chk(wake_pin_oe_n, 1'b1);
        wr(ADDR_LC_CLR, 8'hff);
        wr(ADDR_HC_CLR, 8'hff);
        rd(ADDR_LC_STAT, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_data;
        wr(ADDR_LC_DATA, 8'ha5);
        chk(low_current_port_lines_pad.oe_n, 8'ha5);
        cyc(3);
        rd(ADDR_LC_DATA, 8'ha5);
        wr(ADDR_LC_DATA, 8'hff);
        sw_en <= 8'hff;
        sw_val <= 8'h3c;
        cyc(4);
        rd(ADDR_LC_DATA, 8'h3c);
        sw_en <= 8'h00;
        wr(ADDR_HC_DATA, 8'h0f);
        chk(high_current_port_lines_pad.oe_n, 8'h0f);
        cyc(3);
        rd(ADDR_HC_DATA, 8'h0f);
        wr(ADDR_HC_DATA, 8'hff);
        $display("t_data done");
    endtask : t_data
    task automatic t_cfg;
        wr(ADDR_LC_PU, 8'h0f);
        chk(low_current_pullup_en, 8'h0f);
        rd(ADDR_LC_PU, 8'h00);
        rd(ADDR_HC_PU, 8'h00);
        cyc(3);
        rd(ADDR_LC_DATA, 8'h0f);
        wr(ADDR_LC_PU, 8'hff);
        wr(8'h47, 8'h03);
        chk(low_current_sink_sel[31:28], 4'h3);
        wr(ADDR_DRV_LAST, 8'h09);
        chk(high_current_sink_sel[31:28], 4'h9);
        wr(ADDR_DRV_BASE, 8'h0a);
        rd(8'h47, 8'h03);
        wr(ADDR_HC_LED, 8'h55);
        chk(high_current_led_en, 8'h55);
        rd(8'h20, 8'h00);
        $display("t_cfg done");
    endtask : t_cfg
    task automatic t_irq;
        sw_en <= 8'h02;
        cyc(4);
        wr(ADDR_LC_CLR, 8'hff);
        wr(ADDR_HC_CLR, 8'hff);
        sw_val <= 8'h02;
        cyc(5);
        rd(ADDR_LC_STAT, 8'h02);
        chk(irq, 1'b0);
        wr(ADDR_LC_IE, 8'h02);
        cyc(1);
        chk(irq, 1'b1);
        rd(ADDR_LC_IE, 8'h00);
        wr(ADDR_LC_CLR, 8'h02);
        cyc(1);
        chk(irq, 1'b0);
        wr(ADDR_LC_POL, 8'hfd);
        sw_val <= 8'h00;
        cyc(5);
        chk(irq, 1'b1);
        rd(ADDR_LC_STAT, 8'h02);
        wr(ADDR_LC_CLR, 8'h02);
        wr(ADDR_LC_IE, 8'h00);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_wake;
        wr(ADDR_WK_CLR, 8'h01);
        wr(ADDR_WK_IE, 8'h01);
        wr(ADDR_WK_CTRL, 8'h02);
        chk(suspended, 1'b1);
        wk_rc <= 1'b1;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (wake_pulse === 1'b1) break;
        end
        chk(wake_pulse, 1'b1);
        chk(suspended, 1'b0);
        cyc(1);
        chk(irq, 1'b1);
        rd(ADDR_WK_STAT, 8'h01);
        wr(ADDR_WK_CLR, 8'h01);
        wr(ADDR_WK_CTRL, 8'h01);
        chk(wake_pin_oe_n, 1'b0);
        cyc(4);
        rd(ADDR_WK_STAT, 8'h00);
        chk(irq, 1'b0);
        $display("t_wake done");
    endtask : t_wake
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        cyc(6);
        t_reset;
        t_data;
        t_cfg;
        t_irq;
        t_wake;
        final_report;
    end
    initial begin
        #(8 * 20000);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report;
    end
endmodule : gpd_gpio_test
`default_nettype wire
